//--- mrap_pkg.sv
// Shared constants and types for the multiplexed register access port
package mrap_pkg;
    localparam int        BUS_W        = 8;
    localparam int        MEM_AW       = 4;
    localparam int        MEM_DEPTH    = 16;
    localparam logic [7:0] ADDR_STATUS = 8'h00;
    localparam logic [7:0] ADDR_MASK   = 8'h01;
    localparam logic [7:0] ADDR_MEM_LO = 8'h02;
    localparam logic [7:0] ADDR_MEM_HI = 8'h0F;
    localparam logic [7:0] MASK_RST    = 8'h00;
    localparam logic [7:0] STATUS_RST  = 8'h00;
    localparam logic [7:0] MEM_RST     = 8'h00;
    localparam logic [7:0] ADDR_RST    = 8'h00;
    localparam int        SYNC_STAGES  = 2;

    typedef enum logic [1:0] {
        MRAP_IDLE,
        MRAP_READ,
        MRAP_WRITE
    } mrap_phase_t;
endpackage

//--- mrap_regmem.sv
// Small register memory with registered read data
`timescale 1ns/10ps
`default_nettype none
module mrap_regmem (
    input  wire logic                          sys_clk,
    input  wire logic                          rstn,
    input  wire logic                          we,
    input  wire logic [mrap_pkg::MEM_AW-1:0]   waddr,
    input  wire logic [mrap_pkg::BUS_W-1:0]    wdata,
    input  wire logic [mrap_pkg::MEM_AW-1:0]   raddr,
    output logic      [mrap_pkg::BUS_W-1:0]    rdata
);
    logic [mrap_pkg::BUS_W-1:0] mem [mrap_pkg::MEM_DEPTH];

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < mrap_pkg::MEM_DEPTH; i++) begin
                mem[i] <= mrap_pkg::MEM_RST;
            end
            rdata <= mrap_pkg::MEM_RST;
        end else begin
            if (we) begin
                mem[waddr] <= wdata;
            end
            rdata <= mem[raddr];
        end
    end
endmodule // mrap_regmem
`default_nettype wire

//--- mrap_port.sv
// Register access port on an 8-bit multiplexed address/data bus
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// - Address then data share one 8-bit bus.
// - Latch address on falling address strobe.
// - Drive bus only during an active read.
// - Capture write data when write/select ends.
// - Synchronise all strobes before use.
// - Interrupt stays low until status read or masked.
// - Reset clears all control state.
module mrap_port (
    input  wire logic                        sys_clk,
    input  wire logic                        rstn,
    input  wire logic                        ale,
    input  wire logic                        cs_n,
    input  wire logic                        rd_n,
    input  wire logic                        wr_n,
    input  wire logic [mrap_pkg::BUS_W-1:0]  ad_in,
    output logic      [mrap_pkg::BUS_W-1:0]  ad_out,
    output logic                             ad_oe,
    input  wire logic [mrap_pkg::BUS_W-1:0]  event_in,
    output logic                             int_n_out,
    output logic                             int_n_oe
);
    typedef struct packed {
        logic [1:0]                ale_sy;
        logic [1:0]                cs_n_sy;
        logic [1:0]                rd_n_sy;
        logic [1:0]                wr_n_sy;
        logic [1:0][7:0]           ad_sy;
        logic                      ale_d;
        logic [7:0]                addr;
        logic [7:0]                wdata;
        mrap_pkg::mrap_phase_t     phase;
        logic [7:0]                status;
        logic [7:0]                rd_snap;
        logic [7:0]                mask;
        logic [7:0]                ad_out;
        logic                      ad_oe;
        logic                      int_n_oe;
    } mrap_state_t;

    mrap_state_t st;
    mrap_state_t next_st;

    logic                          mem_we;
    logic [mrap_pkg::BUS_W-1:0]    mem_rdata;

    function automatic logic in_mem(input logic [7:0] a);
        in_mem = (a >= mrap_pkg::ADDR_MEM_LO) && (a <= mrap_pkg::ADDR_MEM_HI);
    endfunction

    function automatic logic [7:0] read_mux(input logic [7:0] a, input logic [7:0] sts,
                                            input logic [7:0] msk, input logic [7:0] mdat);
        if (a == mrap_pkg::ADDR_STATUS) begin
            read_mux = sts;
        end else if (a == mrap_pkg::ADDR_MASK) begin
            read_mux = msk;
        end else if (in_mem(a)) begin
            read_mux = mdat;
        end else begin
            read_mux = 8'h00;
        end
    endfunction

    logic ale_s;
    logic cs_act;
    logic rd_act;
    logic wr_act;
    logic [7:0] ad_s;
    assign ale_s  = st.ale_sy[1];
    assign ad_s   = st.ad_sy[1];
    assign cs_act = !st.cs_n_sy[1];
    assign rd_act = cs_act && !st.rd_n_sy[1] && st.wr_n_sy[1];
    assign wr_act = cs_act && !st.wr_n_sy[1] && st.rd_n_sy[1];

    always_comb begin
        next_st = st;
        mem_we  = 1'b0;
        // Stage one only feeds stage two
        next_st.ale_sy  = {st.ale_sy[0], ale};
        next_st.cs_n_sy = {st.cs_n_sy[0], cs_n};
        next_st.rd_n_sy = {st.rd_n_sy[0], rd_n};
        next_st.wr_n_sy = {st.wr_n_sy[0], wr_n};
        next_st.ad_sy   = {st.ad_sy[0], ad_in};
        next_st.ale_d   = ale_s;
        // Bus still holds the address on the synchronised falling edge
        if (st.ale_d && !ale_s) begin
            next_st.addr = ad_s;
        end
        unique case (st.phase)
            mrap_pkg::MRAP_IDLE: begin
                if (!ale_s && rd_act) begin
                    next_st.phase = mrap_pkg::MRAP_READ;
                    if (st.addr == mrap_pkg::ADDR_STATUS) begin
                        next_st.rd_snap = st.status;
                    end else begin
                        next_st.rd_snap = 8'h00;
                    end
                end else if (!ale_s && wr_act) begin
                    next_st.phase = mrap_pkg::MRAP_WRITE;
                    next_st.wdata = ad_s;
                end
            end
            mrap_pkg::MRAP_READ: begin
                if (!rd_act) begin
                    next_st.phase = mrap_pkg::MRAP_IDLE;
                end
            end
            mrap_pkg::MRAP_WRITE: begin
                if (wr_act) begin
                    next_st.wdata = ad_s;
                end else begin
                    // Last sample taken while strobes were still active
                    next_st.phase = mrap_pkg::MRAP_IDLE;
                    if (st.addr == mrap_pkg::ADDR_MASK) begin
                        next_st.mask = st.wdata;
                    end
                    mem_we = in_mem(st.addr);
                end
            end
        endcase
        // Reading clears only the bits the host actually saw; new events win
        if (st.phase == mrap_pkg::MRAP_READ && !rd_act) begin
            next_st.status = st.status & ~st.rd_snap;
        end
        next_st.status = next_st.status | event_in;
        // Read data refreshes each cycle so memory latency is hidden
        next_st.ad_oe  = (next_st.phase == mrap_pkg::MRAP_READ);
        next_st.ad_out = next_st.ad_oe ? read_mux(st.addr, st.status, st.mask, mem_rdata) : 8'h00;
        next_st.int_n_oe = |(next_st.status & next_st.mask);
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            st.ale_sy   <= 2'b00;
            st.cs_n_sy  <= 2'b11;
            st.rd_n_sy  <= 2'b11;
            st.wr_n_sy  <= 2'b11;
            st.ad_sy    <= 16'h0000;
            st.ale_d    <= 1'b0;
            st.addr     <= mrap_pkg::ADDR_RST;
            st.wdata    <= 8'h00;
            st.phase    <= mrap_pkg::MRAP_IDLE;
            st.status   <= mrap_pkg::STATUS_RST;
            st.rd_snap  <= 8'h00;
            st.mask     <= mrap_pkg::MASK_RST;
            st.ad_out   <= 8'h00;
            st.ad_oe    <= 1'b0;
            st.int_n_oe <= 1'b0;
        end else begin
            st <= next_st;
        end
    end

    mrap_regmem u_regmem (
        .sys_clk (sys_clk),
        .rstn    (rstn),
        .we      (mem_we),
        .waddr   (st.addr[mrap_pkg::MEM_AW-1:0]),
        .wdata   (st.wdata),
        .raddr   (st.addr[mrap_pkg::MEM_AW-1:0]),
        .rdata   (mem_rdata)
    );

    assign ad_out    = st.ad_out;
    assign ad_oe     = st.ad_oe;
    assign int_n_oe  = st.int_n_oe;
    // Open drain: only ever pulls low
    assign int_n_out = 1'b0;
endmodule // mrap_port
`default_nettype wire

//--- mrap_host.sv
// Host processor model for the multiplexed register bus
`timescale 1ns/10ps
`default_nettype none
module mrap_host (
    input  wire logic       sys_clk,
    input  wire logic [7:0] ad_out,
    input  wire logic       ad_oe,
    output logic            ale,
    output logic            cs_n,
    output logic            rd_n,
    output logic            wr_n,
    output logic      [7:0] ad_in
);
    logic [7:0] hd = 8'h00;
    logic [7:0] last = 8'h00;
    logic       drv = 1'b0;
    initial {ale, cs_n, rd_n, wr_n} = 4'h7;
    // Floating bus moves every cycle so a stale byte never passes
    always_comb ad_in = ad_oe ? ad_out : (drv ? hd : ~last);
    always @(posedge sys_clk) last <= ad_in;
    task automatic addr(input logic [7:0] a);
        @(negedge sys_clk);
        {hd, drv, ale} = {a, 2'b11};
        repeat (4) @(negedge sys_clk);
        ale = 1'b0;
        repeat (4) @(negedge sys_clk);
    endtask
    task automatic wr(input logic [7:0] a, d, input logic cs);
        addr(a);
        {hd, cs_n, wr_n} = {d, ~cs, 1'b0};
        repeat (5) @(negedge sys_clk);
        {cs_n, wr_n} = 2'b11;
        repeat (4) @(negedge sys_clk);
        drv = 1'b0;
        repeat (3) @(negedge sys_clk);
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] q);
        addr(a);
        {drv, cs_n, rd_n} = 3'b000;
        repeat (7) @(negedge sys_clk);
        q = ad_in;
        {cs_n, rd_n} = 2'b11;
        repeat (6) @(negedge sys_clk);
    endtask
endmodule // mrap_host
`default_nettype wire

//--- mrap_port_chk.sv
// Pin-level checks of the register access port
`timescale 1ns/10ps
`default_nettype none
module mrap_port_chk (
    input wire logic       sys_clk,
    input wire logic       rstn,
    input wire logic       ale,
    input wire logic       cs_n,
    input wire logic       rd_n,
    input wire logic       wr_n,
    input wire logic [7:0] ad_in,
    input wire logic [7:0] ad_out,
    input wire logic       ad_oe,
    input wire logic [7:0] event_in,
    input wire logic       int_n_out,
    input wire logic       int_n_oe
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    wire logic  rd_on = !rd_n && !cs_n;
    logic [3:0] rd_age;
    // Cycles since a read was last active, saturating
    always_ff @(posedge sys_clk or negedge rstn)
        if (!rstn) rd_age <= 4'hF;
        else rd_age <= rd_on ? 4'h0 : rd_age + {3'h0, rd_age != 4'hF};
    oe_needs_rd_a: assert property (ad_oe |-> $past(rd_on, 3) || $past(rd_on, 4)) else $error("bus driven");
    oe_rise_a: assert property ($fell(rd_n) && !cs_n && wr_n && !ale |-> ##[3:4] ad_oe) else $error("no drive");
    oe_fall_a: assert property ($rose(rd_n) |-> ##[3:4] !ad_oe) else $error("bus kept");
    sync_delay_a: assert property ($fell(rd_n) |-> !ad_oe [*3]) else $error("strobe unsynced");
    idle_zero_a: assert property (!ad_oe |-> ad_out == 8'h00) else $error("idle data");
    int_hold_a: assert property ($fell(int_n_oe) |-> rd_age <= 4'h8) else $error("interrupt dropped");
    cs_ignore_a: assert property (cs_n [*5] |-> !ad_oe) else $error("drive unselected");
    reset_quiet_a: assert property (@(posedge sys_clk) disable iff (1'b0)
        !rstn |-> !ad_oe && !int_n_oe && ad_out == 8'h00) else $error("active in reset");
    cover property ($rose(ad_oe));
    cover property ($rose(int_n_oe));
    cover property ($fell(int_n_oe));
endmodule // mrap_port_chk
bind mrap_port mrap_port_chk chk_u (.sys_clk, .rstn, .ale, .cs_n, .rd_n, .wr_n, .ad_in, .ad_out, .ad_oe,
    .event_in, .int_n_out, .int_n_oe);
`default_nettype wire

//--- mrap_port_tb.sv
// Self-checking bench for the register access port
`timescale 1ns/10ps
`default_nettype none
module mrap_port_tb;
    logic        sys_clk = 1'b0;
    logic        rstn = 1'b1;
    logic        ale, cs_n, rd_n, wr_n, ad_oe, int_n_out, int_n_oe;
    logic [7:0]  ad_in, ad_out, q;
    logic [7:0]  event_in = 8'h00;
    int          err_count = 0;
    int          samples_checked = 0;
    // Address, written byte, expected read-back
    logic [23:0] rows [5] = '{24'h01A5A5, 24'h023C3C, 24'h0FC3C3, 24'h00FF00, 24'h107700};
    initial forever #2.5 sys_clk = ~sys_clk;
    mrap_host host_u (.sys_clk, .ad_out, .ad_oe, .ale, .cs_n, .rd_n, .wr_n, .ad_in);
    mrap_port dut_u (.sys_clk, .rstn, .ale, .cs_n, .rd_n, .wr_n, .ad_in, .ad_out, .ad_oe, .event_in,
        .int_n_out, .int_n_oe);
    task automatic chk(input logic [7:0] got, exp);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic pulse_event;
        event_in = 8'h01;
        @(negedge sys_clk);
        event_in = 8'h00;
        repeat (20) @(negedge sys_clk);
    endtask
    task automatic report_and_stop;
        $display("errors=%0d checks=%0d", err_count, samples_checked);
        if (err_count == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial begin
        // A real falling edge, so the asynchronous reset acts before the first clock edge
        #1;
        rstn = 1'b0;
        repeat (12) @(negedge sys_clk);
        rstn = 1'b1;
        repeat (3) @(negedge sys_clk);
        foreach (rows[i]) begin
            host_u.wr(rows[i][23:16], rows[i][15:8], 1'b1);
            host_u.rd(rows[i][23:16], q);
            chk(q, rows[i][7:0]);
        end
        // Unselected write must leave the old byte
        host_u.wr(8'h02, 8'hFF, 1'b0);
        host_u.rd(8'h02, q);
        chk(q, 8'h3C);
        pulse_event();
        chk({7'h00, int_n_oe}, 8'h01);
        chk({7'h00, int_n_out}, 8'h00);
        host_u.rd(8'h00, q);
        chk(q, 8'h01);
        chk({7'h00, int_n_oe}, 8'h00);
        // Reset in mid-run with an interrupt pending
        pulse_event();
        rstn = 1'b0;
        repeat (2) @(negedge sys_clk);
        rstn = 1'b1;
        repeat (3) @(negedge sys_clk);
        chk({7'h00, int_n_oe}, 8'h00);
        host_u.rd(8'h01, q);
        chk(q, 8'h00);
        report_and_stop();
    end
    initial begin
        #100000;
        err_count++;
        report_and_stop();
    end
endmodule // mrap_port_tb
`default_nettype wire
